// ===== core/io_port_config.sv
module io_port_config
    import port_cfg_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // register bus
    input  cfg_bus_t        bus,
    output logic [7:0]      rdata,
    // sources from the core and pld
    input  wire logic [7:0] addr_lo,
    input  wire logic       addr_latch,
    input  wire logic [7:0] data_out_a,
    input  wire logic [7:0] data_out_b,
    input  wire logic [7:0] data_out_c,
    input  wire logic [7:0] data_out_d,
    input  wire logic [7:0] pt_oe_a,
    input  wire logic [7:0] pt_oe_b,
    input  wire logic [7:0] pt_oe_c,
    input  wire logic [7:0] pt_oe_d,
    input  wire logic [7:0] mc_ab_out,
    input  wire logic [7:0] mc_ab_sel_a,
    input  wire logic [7:0] mc_ab_sel_b,
    input  wire logic [7:0] mc_bc_out,
    input  wire logic [7:0] mc_bc_sel_b,
    input  wire logic [7:0] mc_bc_sel_c,
    input  wire logic [7:0] cpu_wdata,
    input  wire logic       peripheral_select_0,
    input  wire logic       peripheral_select_1,
    input  wire logic       cpu_rd,
    // pin controls
    output pin_ctl_t        pin_a,
    output pin_ctl_t        pin_b,
    output pin_ctl_t        pin_c,
    output pin_ctl_t        pin_d,
    output logic            peripheral_io_enable
);
    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    logic [7:0] func_a_q, func_b_q, dir_a_q, dir_b_q, dir_c_q, dir_d_q;
    logic [7:0] drv_a_q, drv_b_q, drv_c_q, drv_d_q, memsel_q, addr_q;
    pin_ctl_t   a_d, b_d, c_d, d_d;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            func_a_q <= CFG_RESET;
            func_b_q <= CFG_RESET;
            dir_a_q  <= CFG_RESET;
            dir_b_q  <= CFG_RESET;
            dir_c_q  <= CFG_RESET;
            dir_d_q  <= CFG_RESET;
            drv_a_q  <= CFG_RESET;
            drv_b_q  <= CFG_RESET;
            drv_c_q  <= CFG_RESET;
            drv_d_q  <= CFG_RESET;
            memsel_q <= CFG_RESET;
        end else if (bus.wr) begin
            case (bus.addr)
                OFS_FUNC_A: func_a_q <= bus.wdata;
                OFS_FUNC_B: func_b_q <= bus.wdata;
                OFS_DIR_A:  dir_a_q  <= bus.wdata;
                OFS_DIR_B:  dir_b_q  <= bus.wdata;
                OFS_DIR_C:  dir_c_q  <= bus.wdata;
                OFS_DIR_D:  dir_d_q  <= bus.wdata & PORT_D_MASK;
                OFS_DRV_A:  drv_a_q  <= bus.wdata;
                OFS_DRV_B:  drv_b_q  <= bus.wdata;
                OFS_DRV_C:  drv_c_q  <= bus.wdata;
                OFS_DRV_D:  drv_d_q  <= bus.wdata & PORT_D_MASK;
                OFS_MEMSEL: memsel_q <= bus.wdata;
                default:    ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path, registered; unmapped offsets read zero
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata <= CFG_RESET;
        end else if (bus.rd) begin
            case (bus.addr)
                OFS_FUNC_A: rdata <= func_a_q;
                OFS_FUNC_B: rdata <= func_b_q;
                OFS_DIR_A:  rdata <= dir_a_q;
                OFS_DIR_B:  rdata <= dir_b_q;
                OFS_DIR_C:  rdata <= dir_c_q;
                OFS_DIR_D:  rdata <= dir_d_q;
                OFS_DRV_A:  rdata <= drv_a_q;
                OFS_DRV_B:  rdata <= drv_b_q;
                OFS_DRV_C:  rdata <= drv_c_q;
                OFS_DRV_D:  rdata <= drv_d_q;
                OFS_MEMSEL: rdata <= memsel_q;
                default:    rdata <= CFG_RESET;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // latched low address, captured on the strobe
    always_ff @(posedge core_clk) begin
        if (rst) begin
            addr_q <= CFG_RESET;
        end else if (addr_latch) begin
            addr_q <= addr_lo;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-port pin logic
    port_pin_slice #(
        .HAS_FUNC  (8'hff),
        .PIN_MASK  (8'hff),
        .OD_MASK   (~DRV_SLEW_AB),
        .SLEW_MASK (DRV_SLEW_AB)
    ) u_port_a (
        .func_sel     (func_a_q),
        .dir          (dir_a_q),
        .drive_sel    (drv_a_q),
        .pt_oe        (pt_oe_a),
        .data_out     (data_out_a),
        .latched_addr (addr_q),
        .pld_out      (mc_ab_out),
        .pld_sel      (mc_ab_sel_a),
        .ctl          (a_d)
    );

    port_pin_slice #(
        .HAS_FUNC  (8'hff),
        .PIN_MASK  (8'hff),
        .OD_MASK   (~DRV_SLEW_AB),
        .SLEW_MASK (DRV_SLEW_AB)
    ) u_port_b (
        .func_sel     (func_b_q),
        .dir          (dir_b_q),
        .drive_sel    (drv_b_q),
        .pt_oe        (pt_oe_b),
        .data_out     (data_out_b),
        .latched_addr (addr_q),
        .pld_out      (mc_ab_sel_b != 8'h00 ? mc_ab_out : mc_bc_out),
        .pld_sel      (mc_ab_sel_b | mc_bc_sel_b),
        .ctl          (b_d)
    );

    // no function register on c or d, so address mode cannot be reached there
    port_pin_slice #(
        .HAS_FUNC  (8'h00),
        .PIN_MASK  (~PORT_C_JTAG),
        .OD_MASK   (8'hff),
        .SLEW_MASK (8'h00)
    ) u_port_c (
        .func_sel     (CFG_RESET),
        .dir          (dir_c_q),
        .drive_sel    (drv_c_q),
        .pt_oe        (pt_oe_c),
        .data_out     (data_out_c),
        .latched_addr (addr_q),
        .pld_out      (mc_bc_out),
        .pld_sel      (mc_bc_sel_c & PORT_C_MC_MASK),
        .ctl          (c_d)
    );

    port_pin_slice #(
        .HAS_FUNC  (8'h00),
        .PIN_MASK  (PORT_D_MASK),
        .OD_MASK   (8'h00),
        .SLEW_MASK (PORT_D_MASK)
    ) u_port_d (
        .func_sel     (CFG_RESET),
        .dir          (dir_d_q),
        .drive_sel    (drv_d_q),
        .pt_oe        (pt_oe_d),
        .data_out     (data_out_d),
        .latched_addr (addr_q),
        .pld_out      (8'h00),
        .pld_sel      (8'h00),
        .ctl          (d_d)
    );

    ////////////////////////////////////////////////////////////////////////
    // output stage; peripheral mode overrides port a with the data buffer
    // jtag pins are not masked: PORT_C_JTAG is zero, so the c mask leaves every c pin configurable
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_a                <= '0;
            pin_b                <= '0;
            pin_c                <= '0;
            pin_d                <= '0;
            peripheral_io_enable <= 1'b0;
        end else begin
            peripheral_io_enable <= memsel_q[PIO_BIT];
            pin_b                <= b_d;
            pin_c                <= c_d;
            pin_d                <= d_d;
            if (memsel_q[PIO_BIT]) begin
                pin_a.out        <= cpu_wdata;
                // drives only while a select is active and the core is not reading
                pin_a.oe         <= {8{(peripheral_select_0 | peripheral_select_1) & ~cpu_rd}};
                pin_a.open_drain <= a_d.open_drain;
                pin_a.fast_slew  <= a_d.fast_slew;
            end else begin
                pin_a            <= a_d;
            end
        end
    end
endmodule : io_port_config

// ===== core/port_cfg_pkg.sv
// Operation
// - ports a/b: control 0 io, 1 address
// - only ports a/b have control register
// - direction bit 1 output, 0 input
// - output enable is direction or product term
// - inactive product term leaves direction alone
// - all configuration registers reset to zero
// - open-drain pins: drive bit 1 open drain
// - slew pins: drive bit 1 fast slew
// - address mode: pins carry latched a7-a0
// - each bit controls its own pin only
// - port d direction has two active bits
// - registers read/written by normal bus cycles
// - port c macrocells only on pc2,3,4,7
// - port c jtag pins dedicated, not configurable; here PORT_C_JTAG is zero, so all eight c pins are configurable
// - peripheral io enabled by memory select bit7
// - peripheral buffer tri-stated when selects inactive
// - a/b drive bits 3-0 slew, 7-4 open drain
package port_cfg_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register offsets from the base of config_register_space
    localparam logic [7:0] OFS_FUNC_A  = 8'h02;
    localparam logic [7:0] OFS_FUNC_B  = 8'h03;
    localparam logic [7:0] OFS_DIR_A   = 8'h04;
    localparam logic [7:0] OFS_DIR_B   = 8'h05;
    localparam logic [7:0] OFS_DRV_A   = 8'h06;
    localparam logic [7:0] OFS_DRV_B   = 8'h07;
    localparam logic [7:0] OFS_DIR_C   = 8'h14;
    localparam logic [7:0] OFS_DIR_D   = 8'h15;
    localparam logic [7:0] OFS_DRV_C   = 8'h16;
    localparam logic [7:0] OFS_DRV_D   = 8'h17;
    localparam logic [7:0] OFS_MEMSEL  = 8'he2;

    ////////////////////////////////////////////////////////////////////////
    // reset values and field layout
    localparam logic [7:0] CFG_RESET      = 8'h00;
    localparam logic [7:0] PORT_D_MASK    = 8'h06;
    localparam logic [7:0] PORT_C_MC_MASK = 8'h9c;
    localparam logic [7:0] PORT_C_JTAG    = 8'h00;
    localparam logic [7:0] DRV_SLEW_AB    = 8'h0f;
    localparam int         PIO_BIT        = 7;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cfg_bus_t;

    typedef struct packed {
        logic [7:0] oe;
        logic [7:0] out;
        logic [7:0] open_drain;
        logic [7:0] fast_slew;
    } pin_ctl_t;

endpackage : port_cfg_pkg

// ===== core/port_pin_slice.sv
module port_pin_slice
    import port_cfg_pkg::*;
#(
    parameter logic [7:0] HAS_FUNC  = 8'h00,
    parameter logic [7:0] PIN_MASK  = 8'hff,
    parameter logic [7:0] OD_MASK   = 8'h00,
    parameter logic [7:0] SLEW_MASK = 8'h00
) (
    // configuration
    input  wire logic [7:0] func_sel,
    input  wire logic [7:0] dir,
    input  wire logic [7:0] drive_sel,
    // sources
    input  wire logic [7:0] pt_oe,
    input  wire logic [7:0] data_out,
    input  wire logic [7:0] latched_addr,
    input  wire logic [7:0] pld_out,
    input  wire logic [7:0] pld_sel,
    // result
    output pin_ctl_t        ctl
);
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_pin
            always_comb begin
                ctl.oe[i] = PIN_MASK[i] & (dir[i] | pt_oe[i]);
                if (HAS_FUNC[i] && func_sel[i]) begin
                    ctl.out[i] = latched_addr[i];
                end else if (pld_sel[i]) begin
                    ctl.out[i] = pld_out[i];
                end else begin
                    ctl.out[i] = data_out[i];
                end
                ctl.open_drain[i] = OD_MASK[i] & drive_sel[i];
                ctl.fast_slew[i]  = SLEW_MASK[i] & drive_sel[i];
            end
        end
    endgenerate
endmodule : port_pin_slice

// ===== dv/io_port_config_props.sv
module io_port_config_props
    import port_cfg_pkg::*;
(
    // clock and reset
    input wire logic       core_clk,
    input wire logic       rst,
    // observed ports
    input cfg_bus_t        bus,
    input wire logic [7:0] rdata,
    input wire logic [7:0] pt_oe_b,
    input pin_ctl_t        pin_a,
    input pin_ctl_t        pin_b,
    input pin_ctl_t        pin_d,
    input wire logic       peripheral_io_enable,
    input wire logic       peripheral_select_0,
    input wire logic       peripheral_select_1
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    property p_rst_clear; $past(rst) |-> rdata == 8'h00 && !peripheral_io_enable; endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("outputs not clear after reset");
    property p_pt_oe; !$past(rst) |-> (pin_b.oe & $past(pt_oe_b)) == $past(pt_oe_b); endproperty
    a_pt_oe: assert property (p_pt_oe) else $error("product term did not enable driver");
    property p_dir_b;
        bus.wr && bus.addr == OFS_DIR_B ##1 !(bus.wr && bus.addr == OFS_DIR_B)
            |=> (pin_b.oe & $past(bus.wdata, 2)) == $past(bus.wdata, 2);
    endproperty
    a_dir_b: assert property (p_dir_b) else $error("direction write not on pins");
    property p_memsel;
        bus.wr && bus.addr == OFS_MEMSEL && bus.wdata[7] ##1 !(bus.wr && bus.addr == OFS_MEMSEL)
            |-> ##[1:2] peripheral_io_enable;
    endproperty
    a_memsel: assert property (p_memsel) else $error("peripheral mode not enabled");
    property p_periph_off;
        peripheral_io_enable && $past(peripheral_io_enable) && !$past(peripheral_select_0)
            && !$past(peripheral_select_1) |-> pin_a.oe == 8'h00;
    endproperty
    a_periph_off: assert property (p_periph_off) else $error("port a driven without select");
    property p_rd_hold; !$past(bus.rd) && !$past(rst) |-> $stable(rdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data changed without read");
    property p_unmapped; bus.rd && bus.addr == 8'h00 |=> rdata == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_port_d; (pin_d.oe & 8'hf9) == 8'h00 && pin_d.open_drain == 8'h00; endproperty
    a_port_d: assert property (p_port_d) else $error("port d unused bit active");
    property p_drv_split;
        ((pin_a.fast_slew | pin_b.fast_slew) & 8'hf0) == 8'h00
            && ((pin_a.open_drain | pin_b.open_drain) & 8'h0f) == 8'h00;
    endproperty
    a_drv_split: assert property (p_drv_split) else $error("drive bits on wrong pins");
    ////////////////////////////////////////////////////////////////////////
    c_periph: cover property (peripheral_io_enable && pin_a.oe == 8'hff);
    c_pt_oe: cover property (pin_b.oe == 8'h87);
    c_unmapped: cover property (bus.rd && bus.addr == 8'h00);
endmodule : io_port_config_props

// ===== dv/pin_load.sv
module pin_load
    import port_cfg_pkg::*;
(
    // driver side
    input pin_ctl_t     ctl,
    // pad levels
    output logic [7:0]  pad
);
    timeunit 1ns;
    timeprecision 100ps;
    // board pull-ups: a released or open-drain high pin floats up, never holds old value
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pad[i] = (ctl.oe[i] && !(ctl.open_drain[i] && ctl.out[i])) ? ctl.out[i] : 1'b1;
        end
    end
endmodule : pin_load

// ===== dv/tb.sv
module tb;
    import port_cfg_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic       core_clk, rst, addr_latch, peripheral_select_0, peripheral_select_1, cpu_rd;
    logic       peripheral_io_enable;
    cfg_bus_t   bus;
    logic [7:0] rdata, addr_lo, dout, pt, msel, mc_bc_out, mc_bc_sel_c, cpu_wdata, pad;
    pin_ctl_t   pin_a, pin_b, pin_c, pin_d;
    int         num_errors, n_compared, cycles;
    logic [7:0] offs [11] = '{OFS_FUNC_A, OFS_FUNC_B, OFS_DIR_A, OFS_DIR_B, OFS_DRV_A, OFS_DRV_B,
                              OFS_DIR_C, OFS_DRV_C, OFS_DIR_D, OFS_DRV_D, 8'h00};
    io_port_config io_port_config_i (.core_clk, .rst, .bus, .rdata, .addr_lo, .addr_latch,
        .data_out_a(dout), .data_out_b(dout), .data_out_c(dout), .data_out_d(dout),
        .pt_oe_a(pt), .pt_oe_b(pt), .pt_oe_c(pt), .pt_oe_d(pt), .mc_ab_out(mc_bc_out),
        .mc_ab_sel_a(msel), .mc_ab_sel_b(msel), .mc_bc_out, .mc_bc_sel_b(msel), .mc_bc_sel_c,
        .cpu_wdata, .peripheral_select_0, .peripheral_select_1, .cpu_rd,
        .pin_a, .pin_b, .pin_c, .pin_d, .peripheral_io_enable);
    pin_load pin_load_i (.ctl(pin_a), .pad);
    ////////////////////////////////////////////////////////////////////////
    task summarize;
        if (num_errors == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk) bus <= '{1'b1, 1'b0, a, d};
        @(posedge core_clk) bus <= '0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk) bus <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge core_clk) bus <= '0;
        @(negedge core_clk) chk("rdata", e, rdata);
    endtask : rd
    // pins are registered from the config, so a config write gets two falling edges, the latched address three
    task settle(input int n);
        repeat (n) @(negedge core_clk);
    endtask : settle
    ////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            summarize();
        end
    end
    initial begin
        {rst, addr_latch, peripheral_select_0, peripheral_select_1, cpu_rd} = 5'b10000;
        bus = '0;
        {addr_lo, dout, pt, msel, mc_bc_out, mc_bc_sel_c, cpu_wdata} = '0;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        foreach (offs[i]) rd(offs[i], 8'h00);
        rd(OFS_MEMSEL, 8'h00);
        foreach (offs[i]) wr(offs[i], 8'hff);
        foreach (offs[i]) rd(offs[i], (i > 9) ? 8'h00 : (i > 7) ? 8'h06 : 8'hff);
        chk("pin_a.open_drain", 8'hf0, pin_a.open_drain);
        chk("pin_a.fast_slew", 8'h0f, pin_a.fast_slew);
        chk("pin_c.open_drain", 8'hff, pin_c.open_drain);
        chk("pin_d.oe", 8'h06, pin_d.oe);
        chk("pin_d.fast_slew", 8'h06, pin_d.fast_slew);
        chk("pin_b.open_drain", 8'hf0, pin_b.open_drain);
        chk("pin_b.fast_slew", 8'h0f, pin_b.fast_slew);
        chk("pin_c.fast_slew", 8'h00, pin_c.fast_slew);
        chk("pin_c.oe", 8'hff, pin_c.oe);
        // direction is still all ones from the sweep, as address mode needs
        wr(OFS_FUNC_B, 8'h0f);
        @(posedge core_clk) {dout, addr_lo, addr_latch} <= {8'ha0, 8'h3c, 1'b1};
        settle(3);
        chk("pin_b.out", 8'hac, pin_b.out);
        chk("pin_d.out", 8'ha0, pin_d.out);
        wr(OFS_FUNC_B, 8'hff);
        settle(2);
        chk("pin_b.out", 8'h3c, pin_b.out);
        @(posedge core_clk) {rst, addr_latch} <= 2'b10;
        @(posedge core_clk) rst <= 1'b0;
        settle(1);
        chk("pin_b.oe", 8'h00, pin_b.oe);
        wr(OFS_DIR_B, 8'h07);
        settle(2);
        chk("pin_b.oe", 8'h07, pin_b.oe);
        @(posedge core_clk) pt <= 8'h80;
        settle(2);
        chk("pin_b.oe", 8'h87, pin_b.oe);
        @(posedge core_clk) {pt, dout, mc_bc_out, mc_bc_sel_c} <= {8'h00, 8'h00, 8'hff, 8'hff};
        settle(2);
        chk("pin_c.out", 8'h9c, pin_c.out);
        @(posedge core_clk) msel <= 8'h01;
        settle(2);
        chk("pin_b.out", 8'h01, pin_b.out);
        @(posedge core_clk) msel <= 8'h00;
        wr(OFS_DIR_A, 8'h0f);
        settle(2);
        chk("pad", 8'hf0, pad);
        wr(OFS_MEMSEL, 8'h80);
        settle(2);
        chk("pio", 8'h01, {7'h00, peripheral_io_enable});
        chk("pin_a.oe", 8'h00, pin_a.oe);
        @(posedge core_clk) {peripheral_select_0, cpu_wdata} <= {1'b1, 8'h3e};
        settle(2);
        chk("pin_a.oe", 8'hff, pin_a.oe);
        chk("pin_a.out", 8'h3e, pin_a.out);
        @(posedge core_clk) cpu_rd <= 1'b1;
        settle(2);
        chk("pin_a.oe", 8'h00, pin_a.oe);
        @(posedge core_clk) {peripheral_select_0, peripheral_select_1, cpu_rd} <= 3'h2;
        settle(2);
        chk("pin_a.oe", 8'hff, pin_a.oe);
        @(posedge core_clk) peripheral_select_1 <= 1'b0;
        settle(2);
        chk("pin_a.oe", 8'h00, pin_a.oe);
        summarize();
    end
endmodule : tb

bind io_port_config io_port_config_props props_i (.core_clk, .rst, .bus, .rdata, .pt_oe_b,
    .pin_a, .pin_b, .pin_d, .peripheral_io_enable, .peripheral_select_0, .peripheral_select_1);
